/* File: logic/irm_delay.sv */
// Down-counter that pulses done after a loaded number of cycles
module irm_delay #(
  parameter int unsigned W = 12
) (
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic         load,
  input  wire logic [W-1:0] count,
  output logic              done
);
  logic [W-1:0] cnt_q;
  logic         run_q;

  if (W < 2) begin : g_bad_width
    $error("irm_delay: width too small");
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      run_q <= 1'b0;
      done  <= 1'b0;
    end else begin
      done <= 1'b0;
      if (load) begin
        cnt_q <= count;
        run_q <= 1'b1;
      end else if (run_q) begin
        if (cnt_q <= W'(1)) begin
          run_q <= 1'b0;
          done  <= 1'b1;
        end else begin
          cnt_q <= cnt_q - W'(1);
        end
      end
    end
  end
endmodule : irm_delay

/* File: logic/irm_host.sv */
// Host controller driving an IR transceiver's mode-control pins
// Functional notes
// - Programming pulse at most 5 us, longer than setup plus pulse.
// - High bandwidth: shutdown up, 200 ns, transmit up, 50 ns, down.
// - Keep transmit input steady 50 ns after shutdown falls.
// - Low bandwidth: shutdown up, transmit low 50 ns setup, down.
// - Transmit pulse of 200 ns during programming enables remote drive.
// - Never drive both transmit inputs high while out of shutdown.
// - Early interface supply with shutdown low: host raises shutdown. Here reset drives it low and only a command raises it.
// - Remote carrier divisors: 8, 7, 6 at 38.4 kHz, 4.
//
// The register offsets and the AXI4-Lite register port are this design's own decisions.
module irm_host #(
  parameter int unsigned SDPW_CYCLES = irm_pkg::SDPW_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             power_down_ctl,
  output logic             irda_tx_pin,
  output logic             remote_tx_pin
);
  localparam int unsigned CW = 16;

  if (SDPW_CYCLES < 2 || SDPW_CYCLES >= (1 << CW)) begin : g_bad_sdpw
    $error("irm_host: SDPW_CYCLES out of range");
  end
  if (irm_pkg::A_CYC + irm_pkg::B_CYC + irm_pkg::H_CYC
      >= irm_pkg::C_MAX_CYC) begin : g_bad_pulse
    $error("irm_host: programming pulse exceeds limit");
  end

  typedef enum logic [2:0] {
    IRM_IDLE  = 3'b000,
    IRM_SETUP = 3'b001,
    IRM_PULSE = 3'b010,
    IRM_SETTX = 3'b011,
    IRM_HOLD  = 3'b100,
    IRM_SDOWN = 3'b101
  } irm_state_t;

  irm_state_t  state_q;
  logic [2:0]  ctrl_q;
  logic [1:0]  cmd_q;
  logic        fir_q;
  logic        remote_q;
  logic        down_q;
  logic        aw_q;
  logic        w_q;
  logic [3:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic        start;
  logic        blocked;
  logic        dly_load;
  logic [CW-1:0] dly_cnt;
  logic        dly_done;
  logic        wr_go;

  irm_delay #(.W(CW)) u_delay (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .load     (dly_load),
    .count    (dly_cnt),
    .done     (dly_done)
  );

  // Write address and data taken in either order
  assign wr_go = aw_q && w_q && !s_axi_bvalid;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_q          <= 1'b0;
      w_q           <= 1'b0;
      awaddr_q      <= 4'h0;
      wdata_q       <= 32'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= irm_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_q && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready  <= !w_q && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q     <= 1'b1;
        awaddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q     <= 1'b1;
        wdata_q <= s_axi_wdata;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_q         <= 1'b0;
        w_q          <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_q == irm_pkg::OFF_CTRL ||
                         awaddr_q == irm_pkg::OFF_CMD)
                        ? irm_pkg::RESP_OKAY : irm_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Control register; only low byte matters
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= irm_pkg::CTRL_RESET;
    end else if (wr_go && awaddr_q == irm_pkg::OFF_CTRL
                 && s_axi_wstrb[0]) begin
      ctrl_q <= wdata_q[2:0];
    end
  end

  // Command accepted only while idle; dropped when busy
  assign start = wr_go && awaddr_q == irm_pkg::OFF_CMD && s_axi_wstrb[0]
                 && state_q == IRM_IDLE;
  // Both inputs high out of shutdown is never driven
  assign blocked = ctrl_q[irm_pkg::CTRL_TWO_INPUT]
                   && ctrl_q[irm_pkg::CTRL_IRDA_TX]
                   && ctrl_q[irm_pkg::CTRL_REMOTE_TX];

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= irm_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= irm_pkg::RESP_OKAY;
        s_axi_rdata   <= 32'h0;
        unique case (s_axi_araddr)
          irm_pkg::OFF_CTRL:   s_axi_rdata[2:0] <= ctrl_q;
          irm_pkg::OFF_CMD:    s_axi_rdata[1:0] <= cmd_q;
          irm_pkg::OFF_STATUS: s_axi_rdata[4:0] <=
            {blocked, down_q, remote_q, fir_q, state_q != IRM_IDLE};
          default:             s_axi_rresp <= irm_pkg::RESP_SLVERR;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Sequencer for programming and shutdown pulses
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q  <= IRM_IDLE;
      cmd_q    <= irm_pkg::CMD_SIR;
      // Assume device default mode after power-up
      fir_q    <= 1'b0;
      remote_q <= 1'b0;
      down_q   <= 1'b0;
      dly_load <= 1'b0;
      dly_cnt  <= '0;
    end else begin
      dly_load <= 1'b0;
      unique case (state_q)
        IRM_IDLE: if (start) begin
          cmd_q    <= wdata_q[1:0];
          dly_load <= 1'b1;
          if (wdata_q[1:0] == irm_pkg::CMD_SHUTDOWN) begin
            dly_cnt <= CW'(SDPW_CYCLES);
            state_q <= IRM_SDOWN;
          end else begin
            dly_cnt <= down_q ? CW'(irm_pkg::H_CYC)
                              : CW'(irm_pkg::A_CYC);
            state_q <= down_q ? IRM_HOLD : IRM_SETUP;
          end
        end
        IRM_SETUP: if (dly_done) begin
          dly_load <= 1'b1;
          if (cmd_q == irm_pkg::CMD_REMOTE) begin
            dly_cnt <= CW'(irm_pkg::B_CYC);
            state_q <= IRM_PULSE;
          end else begin
            dly_cnt <= CW'(irm_pkg::S_CYC);
            state_q <= IRM_SETTX;
          end
        end
        IRM_PULSE: if (dly_done) begin
          dly_load <= 1'b1;
          dly_cnt  <= CW'(irm_pkg::H_CYC);
          state_q  <= IRM_HOLD;
        end
        IRM_SETTX: if (dly_done) begin
          // Falling edge of shutdown latches bandwidth
          fir_q    <= (cmd_q == irm_pkg::CMD_FIR);
          remote_q <= 1'b0;
          down_q   <= 1'b0;
          dly_load <= 1'b1;
          dly_cnt  <= CW'(irm_pkg::H_CYC);
          state_q  <= IRM_HOLD;
        end
        IRM_HOLD: if (dly_done) begin
          state_q <= IRM_IDLE;
          if (down_q) begin
            // Pin dropped out of shutdown first; else the pulse runs long
            down_q   <= 1'b0;
            dly_load <= 1'b1;
            dly_cnt  <= CW'(irm_pkg::A_CYC);
            state_q  <= IRM_SETUP;
          end else if (cmd_q == irm_pkg::CMD_REMOTE) begin
            remote_q <= 1'b1;
          end
        end
        IRM_SDOWN: if (dly_done) begin
          fir_q    <= 1'b0;
          remote_q <= 1'b0;
          down_q   <= 1'b1;
          state_q  <= IRM_IDLE;
        end
        default: state_q <= IRM_IDLE;
      endcase
    end
  end

  // Pin drivers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      power_down_ctl <= 1'b0;
      irda_tx_pin    <= 1'b0;
      remote_tx_pin  <= 1'b0;
    end else begin
      unique case (state_q)
        IRM_IDLE: begin
          power_down_ctl <= down_q;
          if (down_q) begin
            irda_tx_pin   <= 1'b0;
            remote_tx_pin <= 1'b0;
          end else if (ctrl_q[irm_pkg::CTRL_TWO_INPUT]) begin
            irda_tx_pin   <= ctrl_q[irm_pkg::CTRL_IRDA_TX] && !blocked;
            remote_tx_pin <= ctrl_q[irm_pkg::CTRL_REMOTE_TX];
          end else begin
            irda_tx_pin   <= ctrl_q[irm_pkg::CTRL_IRDA_TX];
            remote_tx_pin <= 1'b0;
          end
        end
        IRM_SETUP: begin
          power_down_ctl <= 1'b1;
          irda_tx_pin    <= 1'b0;
          remote_tx_pin  <= 1'b0;
        end
        IRM_PULSE: begin
          power_down_ctl <= 1'b1;
          irda_tx_pin    <= 1'b1;
        end
        IRM_SETTX: begin
          power_down_ctl <= 1'b1;
          irda_tx_pin    <= (cmd_q == irm_pkg::CMD_FIR);
        end
        IRM_HOLD: begin
          // Transmit level kept until hold ends
          power_down_ctl <= 1'b0;
        end
        IRM_SDOWN: begin
          power_down_ctl <= 1'b1;
          irda_tx_pin    <= 1'b0;
          remote_tx_pin  <= 1'b0;
        end
        default: power_down_ctl <= 1'b1;
      endcase
    end
  end
endmodule : irm_host

/* File: logic/irm_pkg.sv */
// Package: timing, register map and command codes of the IR mode host
package irm_pkg;
  localparam int unsigned CLK_PERIOD_NS   = 10;
  // Times in their own unit, counts derived
  localparam int unsigned T_SDPW_US       = 30;
  localparam int unsigned T_A_NS          = 200;
  localparam int unsigned T_B_NS          = 200;
  localparam int unsigned T_S_NS          = 50;
  localparam int unsigned T_H_NS          = 50;
  localparam int unsigned T_C_MAX_NS      = 5000;
  localparam int unsigned SDPW_CYC  = (T_SDPW_US * 1000 + CLK_PERIOD_NS - 1)
                                      / CLK_PERIOD_NS;
  localparam int unsigned A_CYC     = (T_A_NS + CLK_PERIOD_NS - 1)
                                      / CLK_PERIOD_NS;
  localparam int unsigned B_CYC     = (T_B_NS + CLK_PERIOD_NS - 1)
                                      / CLK_PERIOD_NS;
  localparam int unsigned S_CYC     = (T_S_NS + CLK_PERIOD_NS - 1)
                                      / CLK_PERIOD_NS;
  localparam int unsigned H_CYC     = (T_H_NS + CLK_PERIOD_NS - 1)
                                      / CLK_PERIOD_NS;
  localparam int unsigned C_MAX_CYC = T_C_MAX_NS / CLK_PERIOD_NS;
  // Register byte offsets
  localparam logic [3:0] OFF_CTRL   = 4'h0;
  localparam logic [3:0] OFF_CMD    = 4'h4;
  localparam logic [3:0] OFF_STATUS = 4'h8;
  // Control fields
  localparam int unsigned CTRL_TWO_INPUT = 0;
  localparam int unsigned CTRL_IRDA_TX   = 1;
  localparam int unsigned CTRL_REMOTE_TX = 2;
  localparam logic [2:0]  CTRL_RESET     = 3'h0;
  // Command codes
  localparam logic [1:0] CMD_SHUTDOWN = 2'h0;
  localparam logic [1:0] CMD_SIR      = 2'h1;
  localparam logic [1:0] CMD_FIR      = 2'h2;
  localparam logic [1:0] CMD_REMOTE   = 2'h3;
  // Status fields
  localparam int unsigned ST_BUSY     = 0;
  localparam int unsigned ST_FIR      = 1;
  localparam int unsigned ST_REMOTE   = 2;
  localparam int unsigned ST_SHUTDOWN = 3;
  localparam int unsigned ST_BLOCKED  = 4;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : irm_pkg

/* File: verification/irm_dev_model.sv */
// Behavioural model of the transceiver's mode-control pins
module irm_dev_model #(
  parameter int unsigned SDPW_NS = 30000
) (
  input  wire logic power_down_ctl,
  input  wire logic irda_tx_pin,
  input  wire logic remote_tx_pin,
  output logic      mode_fir,
  output logic      mode_remote,
  output logic      down,
  output logic      led_on
);
  timeunit 1ns;
  timeprecision 1ps;
  time t_sd, t_tx;
  initial begin
    mode_fir = 1'b0;
    mode_remote = 1'b0;
    down = 1'b0;
  end
  always @(posedge power_down_ctl) t_sd = $time;
  always @(posedge irda_tx_pin) t_tx = $time;
  // Polled each ns: coarse, but far finer than any limit
  always #1 if (power_down_ctl === 1'b1 && $time - t_sd >= SDPW_NS) begin
    down = 1'b1;
    mode_fir = 1'b0;
    mode_remote = 1'b0;
  end
  always @(negedge power_down_ctl) begin
    if (down) down = 1'b0;
    else if ($time > 0) begin
      mode_fir = irda_tx_pin;
      mode_remote = irda_tx_pin && $time - t_tx >= irm_pkg::T_B_NS;
    end
  end
  // Both inputs high leaves the emitter dark
  assign led_on = !power_down_ctl
                  && (irda_tx_pin ^ remote_tx_pin);
endmodule : irm_dev_model

/* File: verification/irm_host_bench.sv */
// Self-checking bench of the IR mode host against a device model
module irm_host_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk, rst_n, s_axi_awvalid, s_axi_awready;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, v, m;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r, c;
  logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        power_down_ctl, irda_tx_pin, remote_tx_pin;
  logic        mode_fir, mode_remote, down, led_on;
  logic [2:0]  k;
  logic [1:0]  e;
  int          errors, compares, n;
  irm_host #(.SDPW_CYCLES(60)) i_dut (
    .core_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .power_down_ctl, .irda_tx_pin,
    .remote_tx_pin
  );
  irm_dev_model #(.SDPW_NS(600)) i_dev (
    .power_down_ctl, .irda_tx_pin, .remote_tx_pin, .mode_fir,
    .mode_remote, .down, .led_on
  );
  task automatic complete_run();
    if (errors == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  // Second write lands while busy and must be dropped
  task automatic cmd(input logic [1:0] cc, input bit twice);
    wr(irm_pkg::OFF_CMD, {30'h0, cc});
    if (twice) wr(irm_pkg::OFF_CMD, 32'h1);
    do rd(irm_pkg::OFF_STATUS); while (v[irm_pkg::ST_BUSY] !== 1'b0);
    repeat (4) @(posedge core_clk);
    rd(irm_pkg::OFF_STATUS);
  endtask : cmd
  function automatic logic [31:0] exp_st(input logic [1:0] cc);
    exp_st = 32'h0;
    exp_st[irm_pkg::ST_FIR] = (cc == irm_pkg::CMD_FIR);
    exp_st[irm_pkg::ST_REMOTE] = (cc == irm_pkg::CMD_REMOTE);
    exp_st[irm_pkg::ST_SHUTDOWN] = (cc == irm_pkg::CMD_SHUTDOWN);
  endfunction : exp_st
  // Two-input mode with both high keeps the IrDA pin dark
  function automatic logic [1:0] exp_pins(input logic [2:0] ctl);
    exp_pins = {ctl[0] && ctl[2], ctl[1] && !(ctl[0] && ctl[2])};
  endfunction : exp_pins
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    #200000;
    errors++;
    complete_run();
  end
  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    s_axi_wstrb = 4'hF;
    rst_n = 1'b0;
    errors = 0;
    compares = 0;
    v = $urandom(12653);
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(irm_pkg::OFF_STATUS);
    chk(v, 32'h0);
    chk(32'(mode_fir), 32'h0);
    rd(4'hC);
    chk(32'(r), 32'(irm_pkg::RESP_SLVERR));
    wr(4'hC, 32'hFFFFFFFF);
    chk(32'(r), 32'(irm_pkg::RESP_SLVERR));
    for (int i = 0; i < 6; i++) begin
      c = 2'(12'h87B >> (2 * i));
      cmd(c, i == 5);
      m = (c == irm_pkg::CMD_REMOTE) ? 32'hFFFFFFFD : 32'hFFFFFFFF;
      chk(v & m, exp_st(c));
      chk(32'(mode_remote), 32'(c == irm_pkg::CMD_REMOTE));
      chk(32'(down), 32'(c == irm_pkg::CMD_SHUTDOWN));
      if (c != irm_pkg::CMD_REMOTE) begin
        chk(32'(mode_fir), 32'(c == irm_pkg::CMD_FIR));
      end
    end
    for (int i = 0; i < 12; i++) begin
      k = (i == 0) ? 3'h7 : (i == 1) ? 3'h6 : 3'($urandom);
      wr(irm_pkg::OFF_CTRL, {29'h0, k});
      e = exp_pins(k);
      n = 0;
      while ({remote_tx_pin, irda_tx_pin} !== e && n < 16) begin
        @(posedge core_clk);
        n++;
      end
      chk(32'({remote_tx_pin, irda_tx_pin}), 32'(e));
      chk(32'(led_on), 32'(e[0] ^ e[1]));
      rd(irm_pkg::OFF_CTRL);
      chk(v, {29'h0, k});
      rd(irm_pkg::OFF_STATUS);
      chk(32'({v[irm_pkg::ST_FIR], mode_fir}), 32'h3);
      chk(32'(v[irm_pkg::ST_BLOCKED]), 32'(k == 3'h7));
    end
    complete_run();
  end
endmodule : irm_host_bench

bind irm_host irm_properties #(.SDPW_CYCLES(SDPW_CYCLES)) i_props (
  .core_clk, .rst_n, .s_axi_awready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .power_down_ctl, .irda_tx_pin, .remote_tx_pin
);

/* File: verification/irm_properties.sv */
// Checker: answer holding and mode-pin timing of the IR host
module irm_properties #(
  parameter int unsigned SDPW_CYCLES = 3000
) (
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic       s_axi_awready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready,
  input wire logic       power_down_ctl,
  input wire logic       irda_tx_pin,
  input wire logic       remote_tx_pin
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic [15:0] hi_q;
  logic [15:0] hi_d;
  // Cycles the shutdown pin has stood high
  assign hi_d = power_down_ctl ? hi_q + 16'h0001 : 16'h0000;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) hi_q <= 16'h0000;
    else hi_q <= hi_d;
  end
  a_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer not held");
  a_rvalid_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read answer not held");
  a_rvalid_next: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_ready_pending: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("address ready while answer pending");
  a_tx_exclusive: assert property (
    !power_down_ctl |-> !(irda_tx_pin && remote_tx_pin))
    else $error("both transmit pins high");
  a_prog_setup: assert property (
    $fell(power_down_ctl) |-> hi_q >= irm_pkg::A_CYC + irm_pkg::S_CYC)
    else $error("programming pulse too short");
  a_rise_setup: assert property (
    power_down_ctl && $rose(irda_tx_pin) |-> hi_q >= irm_pkg::A_CYC)
    else $error("transmit raised too soon");
  a_tx_hold: assert property (
    $fell(power_down_ctl) |-> ($stable(irda_tx_pin) && !power_down_ctl)[*5])
    else $error("transmit not held after latch");
  c_fall_high: cover property ($fell(power_down_ctl) && irda_tx_pin);
  c_shutdown: cover property (hi_q == 16'(SDPW_CYCLES));
  c_error: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule : irm_properties
